/* File: verilog/ata_set_features_decoder.v */
// set-features and set-max command decoder with feature configuration state
`timescale 1ns/10ps
`include "ata_set_features_consts.vh"
module ata_set_features_decoder #(
    parameter [7:0] CUR_MIN = 8'h04,
    parameter [7:0] CUR_MAX = 8'h0A,
    parameter EXT_POWER = 1
) (
    input wire clk,
    input wire rst_n,
    input wire cmdStrobe,
    input wire [7:0] cmdOpcode,
    input wire [7:0] featureIn,
    input wire [7:0] sectorCountIn,
    input wire softReset,
    input wire flushDone,
    output reg cmdDone,
    output reg cmdAbort,
    output reg busy,
    output reg flushReq,
    output reg mode8Bit,
    output reg assert16Cycle,
    output reg writeCacheOn,
    output reg [4:0] xferType,
    output reg [2:0] xferMode,
    output reg iordyOff,
    output reg [2:0] pioMode,
    output reg dmaOn,
    output reg [2:0] dmaMode,
    output reg apmOn,
    output reg [7:0] apmLevel,
    output reg apmStandby,
    output reg pl1On,
    output reg extPowerOn,
    output reg lookAheadOn,
    output reg [7:0] longBytes,
    output reg [7:0] curLimit,
    output reg [7:0] cylLowOut,
    output reg [7:0] cylHighOut,
    output reg cylValid,
    output reg porDefaultsOnSoft,
    output reg [3:0] setMaxSel
);
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_FLUSH = 3'b010;
    localparam [2:0] ST_DONE = 3'b100;
    localparam [0:0] PL1_DEF = (EXT_POWER != 0) ? 1'b1 : 1'b0;

    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg abort_next;
    wire levelValid;
    wire withStandby;
    wire [7:0] clampedCur;
    wire [4:0] modeType = sectorCountIn[7:3];
    wire [2:0] modeNum = sectorCountIn[2:0];
    wire take = cmdStrobe && (state_reg == ST_IDLE);
    // software reset restores defaults only while enabled
    wire defaultsNow = softReset && porDefaultsOnSoft;

    ata_level_classifier #(
        .CUR_MIN(CUR_MIN),
        .CUR_MAX(CUR_MAX)
    ) u_class (
        .level(sectorCountIn),
        .levelValid(levelValid),
        .withStandby(withStandby),
        .clampedCur(clampedCur)
    );

    // R19: validity of subcommand
    always @* begin
        abort_next = 1'b1;
        if (cmdOpcode == `OP_SET_FEATURES) begin
            case (featureIn)
                `SF_EN8BIT, `SF_DIS8BIT, `SF_ENWCACHE, `SF_DISWCACHE,
                `SF_ENXPWR, `SF_DISXPWR, `SF_ENPL1, `SF_DISPL1,
                `SF_DISRLA, `SF_ENRLA, `SF_LONG4, `SF_DISPORDEF, `SF_ENPORDEF,
                `SF_NOP69, `SF_NOP96, `SF_NOP97, `SF_CURLIMIT,
                `SF_DISAPM: abort_next = 1'b0;
                // R7: level must be a defined one
                `SF_ENAPM: abort_next = !levelValid;
                // R6: reserved types aborted
                `SF_XFERMODE: begin
                    if (modeType == `XT_PIODEF) begin
                        abort_next = (modeNum > `XM_NOIORDY);
                    end else if (modeType == `XT_PIOFC) begin
                        abort_next = (modeNum > `PIO_MAX_MODE);
                    end else if (modeType == `XT_MWDMA) begin
                        abort_next = (modeNum > `DMA_MAX_MODE);
                    end else begin
                        abort_next = 1'b1;
                    end
                end
                default: abort_next = 1'b1;
            endcase
        end else if (cmdOpcode == `OP_SET_MAX) begin
            // R18: reserved set-max values
            abort_next = (featureIn > `SM_FREEZE) || (featureIn == `SM_OBSOLETE);
        end
    end

    // command sequencing: flush must finish before a write cache disable completes
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (take && !abort_next && cmdOpcode == `OP_SET_FEATURES &&
                    featureIn == `SF_DISWCACHE) begin
                    state_next = ST_FLUSH;
                end else if (take) begin
                    state_next = ST_DONE;
                end
            end
            // R3: wait for flush
            ST_FLUSH: begin
                if (flushDone) begin
                    state_next = ST_DONE;
                end
            end
            ST_DONE: state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    // status handshake outputs
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            cmdDone <= 1'b0;
            cmdAbort <= 1'b0;
            busy <= 1'b0;
            flushReq <= 1'b0;
            cylValid <= 1'b0;
            cylLowOut <= 8'h00;
            cylHighOut <= 8'h00;
            setMaxSel <= 4'h0;
        end else begin
            state_reg <= state_next;
            cmdDone <= (state_next == ST_DONE);
            busy <= (state_next != ST_IDLE);
            flushReq <= (state_next == ST_FLUSH);
            if (take) begin
                cmdAbort <= abort_next;
                cylValid <= 1'b0;
                setMaxSel <= 4'h0;
                // R13: report supported range
                if (!abort_next && cmdOpcode == `OP_SET_FEATURES &&
                    featureIn == `SF_CURLIMIT) begin
                    cylLowOut <= CUR_MIN;
                    cylHighOut <= CUR_MAX;
                    cylValid <= 1'b1;
                end
                // R18: one-hot set-max selection
                if (!abort_next && cmdOpcode == `OP_SET_MAX) begin
                    setMaxSel <= 4'h1 << (featureIn[1:0] - 2'h1);
                end
            end
        end
    end

    // configuration state; defaults other than porDefaultsOnSoft written twice, once in the reset branch and once in the soft reset branch
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode8Bit <= 1'b0;
            assert16Cycle <= 1'b1;
            writeCacheOn <= 1'b0;
            xferType <= `XT_PIODEF;
            xferMode <= `XM_DEF;
            iordyOff <= 1'b0;
            pioMode <= 3'h0;
            dmaOn <= 1'b0;
            dmaMode <= 3'h0;
            apmOn <= 1'b0;
            apmLevel <= `APM_MAXPERF;
            apmStandby <= 1'b0;
            pl1On <= PL1_DEF;
            extPowerOn <= 1'b0;
            lookAheadOn <= 1'b0;
            longBytes <= `LONG_BYTES_DEF;
            // R14: highest current default
            curLimit <= CUR_MAX;
            porDefaultsOnSoft <= 1'b1;
        end else if (defaultsNow) begin
            mode8Bit <= 1'b0;
            assert16Cycle <= 1'b1;
            writeCacheOn <= 1'b0;
            xferType <= `XT_PIODEF;
            xferMode <= `XM_DEF;
            iordyOff <= 1'b0;
            pioMode <= 3'h0;
            dmaOn <= 1'b0;
            dmaMode <= 3'h0;
            apmOn <= 1'b0;
            apmLevel <= `APM_MAXPERF;
            apmStandby <= 1'b0;
            pl1On <= PL1_DEF;
            extPowerOn <= 1'b0;
            lookAheadOn <= 1'b0;
            longBytes <= `LONG_BYTES_DEF;
            curLimit <= CUR_MAX;
        end else if (take && !abort_next && cmdOpcode == `OP_SET_FEATURES) begin
            // R1: decode features register
            case (featureIn)
                // R2: byte-lane selection
                `SF_EN8BIT: begin
                    mode8Bit <= 1'b1;
                    assert16Cycle <= 1'b0;
                end
                `SF_DIS8BIT: begin
                    mode8Bit <= 1'b0;
                    assert16Cycle <= 1'b1;
                end
                // R3: write cache enable
                `SF_ENWCACHE: writeCacheOn <= 1'b1;
                `SF_DISWCACHE: writeCacheOn <= 1'b0;
                // R4: take mode byte
                `SF_XFERMODE: begin
                    xferType <= modeType;
                    xferMode <= modeNum;
                    // R5: pio mode always held
                    if (modeType == `XT_PIODEF) begin
                        pioMode <= 3'h0;
                        iordyOff <= (modeNum == `XM_NOIORDY);
                    end else if (modeType == `XT_PIOFC) begin
                        pioMode <= modeNum;
                        iordyOff <= 1'b0;
                    end else begin
                        // R6: multiword dma select
                        dmaOn <= 1'b1;
                        dmaMode <= modeNum;
                    end
                end
                // R7: adopt apm level
                `SF_ENAPM: begin
                    apmOn <= 1'b1;
                    apmLevel <= sectorCountIn;
                    apmStandby <= withStandby;
                end
                // R9: apm disable
                `SF_DISAPM: begin
                    apmOn <= 1'b0;
                    apmStandby <= 1'b0;
                end
                `SF_ENXPWR: extPowerOn <= 1'b1;
                `SF_DISXPWR: extPowerOn <= 1'b0;
                // R10: power level 1
                `SF_ENPL1: pl1On <= 1'b1;
                `SF_DISPL1: pl1On <= 1'b0;
                // R11: look-ahead and long bytes
                `SF_ENRLA: lookAheadOn <= 1'b1;
                `SF_DISRLA: lookAheadOn <= 1'b0;
                `SF_LONG4: longBytes <= `LONG_BYTES_DEF;
                // R12: limit is a quarter of the current, clamped
                `SF_CURLIMIT: curLimit <= clampedCur;
                // R16: soft reset defaults
                `SF_DISPORDEF: porDefaultsOnSoft <= 1'b0;
                `SF_ENPORDEF: porDefaultsOnSoft <= 1'b1;
                // R17: accepted no operation
                default: curLimit <= curLimit;
            endcase
        end
    end
endmodule // ata_set_features_decoder

/* File: verilog/ata_set_features_consts.vh */
// constants for the set-features / set-max command decoder
// What this block does
// R1: opcode EFH, subcommand from features, parameter sector count
// R2: 01H forces 8-bit lanes, 81H restores 16-bit
// R3: 02H/82H write cache; flush before disable completes
// R4: 03H mode byte: type bits 7:3, mode 2:0
// R5: exactly one PIO mode always selected
// R6: decode PIO default, no-IORDY, flow-control, multiword DMA
// R7: 05H adopts sector count as power level
// R8: classify power levels; FFH and 00H reserved
// R9: 85H disables advanced power management
// R10: 0AH/8AH power level 1 commands, default enabled; the code defaults to enabled only when EXT_POWER is nonzero
// R11: look-ahead off default; AAH on, 55H off
// R12: 9AH sector count is quarter of current
// R13: report supported range in cylinder low/high
// R14: current limit resets to highest performance
// R15: out-of-range limit accepted and clamped
// R16: 66H/CCH control software-reset default restore
// R17: 69H, 96H, 97H accepted as no operation
// R18: F9H subcommand from features; 05H-FFH reserved
// R19: unsupported subcommands aborted as invalid
`ifndef ATA_SET_FEATURES_CONSTS_VH
`define ATA_SET_FEATURES_CONSTS_VH
`define OP_SET_FEATURES 8'hEF
`define OP_SET_MAX 8'hF9
`define SF_EN8BIT 8'h01
`define SF_ENWCACHE 8'h02
`define SF_XFERMODE 8'h03
`define SF_ENAPM 8'h05
`define SF_ENXPWR 8'h09
`define SF_ENPL1 8'h0A
`define SF_DISRLA 8'h55
`define SF_DISPORDEF 8'h66
`define SF_NOP69 8'h69
`define SF_DIS8BIT 8'h81
`define SF_DISWCACHE 8'h82
`define SF_DISAPM 8'h85
`define SF_DISXPWR 8'h89
`define SF_DISPL1 8'h8A
`define SF_NOP96 8'h96
`define SF_NOP97 8'h97
`define SF_CURLIMIT 8'h9A
`define SF_LONG4 8'hBB
`define SF_ENRLA 8'hAA
`define SF_ENPORDEF 8'hCC
`define SM_OBSOLETE 8'h00
`define SM_SETPW 8'h01
`define SM_LOCK 8'h02
`define SM_UNLOCK 8'h03
`define SM_FREEZE 8'h04
`define XT_PIODEF 5'h00
`define XT_PIOFC 5'h01
`define XT_MWDMA 5'h04
`define XM_DEF 3'h0
`define XM_NOIORDY 3'h1
`define APM_MAXPERF 8'hFE
`define APM_MINNOSTBY 8'h80
`define APM_MINSTBY 8'h01
`define APM_RES_HI 8'hFF
`define APM_RES_LO 8'h00
`define LONG_BYTES_DEF 8'h04
`define PIO_MAX_MODE 3'h4
`define DMA_MAX_MODE 3'h2
`endif

/* File: verilog/ata_level_classifier.v */
// classifies an advanced power management level and clamps a current limit
`timescale 1ns/10ps
`include "ata_set_features_consts.vh"
module ata_level_classifier #(
    parameter [7:0] CUR_MIN = 8'h04,
    parameter [7:0] CUR_MAX = 8'h0A
) (
    input wire [7:0] level,
    output reg levelValid,
    output reg withStandby,
    output reg [7:0] clampedCur
);
    // R8: level classes
    always @* begin
        levelValid = 1'b1;
        withStandby = 1'b0;
        if (level == `APM_RES_HI || level == `APM_RES_LO) begin
            levelValid = 1'b0;
        end else if (level < `APM_MINNOSTBY) begin
            withStandby = 1'b1; // 01H..7FH may enter standby
        end
    end

    // R15: clamp out of range
    always @* begin
        if (level < CUR_MIN) begin
            clampedCur = CUR_MIN;
        end else if (level > CUR_MAX) begin
            clampedCur = CUR_MAX;
        end else begin
            clampedCur = level;
        end
    end
endmodule // ata_level_classifier

/* File: verification/ata_set_features_decoder_properties.sv */
// checker for the set-features decoder's command handling
`timescale 1ns/10ps
module ata_set_features_decoder_properties #(
    parameter [7:0] CUR_MIN = 8'h04,
    parameter [7:0] CUR_MAX = 8'h0A
) (
    input logic clk,
    input logic rst_n,
    input logic cmdStrobe,
    input logic [7:0] cmdOpcode,
    input logic [7:0] featureIn,
    input logic [7:0] sectorCountIn,
    input logic softReset,
    input logic flushDone,
    input logic cmdDone,
    input logic cmdAbort,
    input logic busy,
    input logic flushReq,
    input logic mode8Bit,
    input logic assert16Cycle,
    input logic writeCacheOn,
    input logic apmOn,
    input logic [7:0] apmLevel,
    input logic apmStandby,
    input logic [7:0] curLimit,
    input logic [3:0] setMaxSel
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // a command taken at this edge with a given opcode and subcommand
    sequence sTake(op, f);
        cmdStrobe && !busy && !cmdDone && !softReset && cmdOpcode == op && featureIn == f;
    endsequence
    // completion is registered from the next state, so it shows one cycle after the take
    chk_done_latency: assert property (
        cmdStrobe && !busy && !cmdDone && !(cmdOpcode == 8'hEF && featureIn == 8'h82)
        |=> cmdDone) else $error("completion not one cycle after take");
    chk_width_pair: assert property (
        assert16Cycle == !mode8Bit) else $error("wide cycle flag disagrees with byte mode");
    chk_enter_narrow: assert property (
        sTake(8'hEF, 8'h01) |=> mode8Bit && cmdDone && !cmdAbort)
        else $error("byte mode not entered");
    chk_cache_off: assert property (
        sTake(8'hEF, 8'h82) |=> !writeCacheOn && flushReq && busy)
        else $error("cache disable did not start flush");
    chk_flush_gate: assert property (
        flushReq && !flushDone |=> !cmdDone) else $error("completion before flush done");
    chk_apm_adopt: assert property (
        sTake(8'hEF, 8'h05) ##0 (sectorCountIn != 8'h00 && sectorCountIn != 8'hFF)
        |=> apmOn && apmLevel == $past(sectorCountIn)) else $error("power level not adopted");
    chk_apm_class: assert property (
        apmOn |-> apmStandby == (apmLevel < 8'h80)) else $error("standby class wrong");
    chk_cur_range: assert property (
        curLimit >= CUR_MIN && curLimit <= CUR_MAX) else $error("current limit not clamped");
    chk_setmax_sel: assert property (
        cmdStrobe && !busy && !cmdDone && cmdOpcode == 8'hF9 && featureIn inside {[8'h01:8'h04]}
        |=> setMaxSel == (4'h1 << ($past(featureIn) - 8'h01))) else $error("set-max select wrong");
    chk_bad_opcode: assert property (
        cmdStrobe && !busy && !cmdDone && cmdOpcode != 8'hEF && cmdOpcode != 8'hF9
        |=> cmdDone && cmdAbort) else $error("unknown opcode not aborted");
endmodule // ata_set_features_decoder_properties
bind ata_set_features_decoder ata_set_features_decoder_properties #(.CUR_MIN(CUR_MIN),
    .CUR_MAX(CUR_MAX)) chk_u (.clk(clk), .rst_n(rst_n), .cmdStrobe(cmdStrobe),
    .cmdOpcode(cmdOpcode), .featureIn(featureIn), .sectorCountIn(sectorCountIn),
    .softReset(softReset), .flushDone(flushDone), .cmdDone(cmdDone), .cmdAbort(cmdAbort),
    .busy(busy), .flushReq(flushReq), .mode8Bit(mode8Bit), .assert16Cycle(assert16Cycle),
    .writeCacheOn(writeCacheOn), .apmOn(apmOn), .apmLevel(apmLevel),
    .apmStandby(apmStandby), .curLimit(curLimit), .setMaxSel(setMaxSel));

/* File: verification/ata_host_model.sv */
// host side model: loads the task file and starts one command
`timescale 1ns/10ps
module ata_host_model (
    input logic clk,
    input logic cmdDone,
    output logic cmdStrobe,
    output logic [7:0] cmdOpcode,
    output logic [7:0] featureIn,
    output logic [7:0] sectorCountIn
);
    initial begin
        cmdStrobe = 1'b0;
        {cmdOpcode, featureIn, sectorCountIn} = 24'h000000;
    end
    // parameter and subcommand loaded with the opcode
    task automatic issue(input logic [7:0] op, f, sc, output int lat);
        @(negedge clk);
        {cmdOpcode, featureIn, sectorCountIn} = {op, f, sc};
        cmdStrobe = 1'b1;
        @(negedge clk);
        cmdStrobe = 1'b0;
        // stale values would hide a late sample, so show the inverse
        {cmdOpcode, featureIn, sectorCountIn} = ~{op, f, sc};
        lat = 0;
        while (cmdDone !== 1'b1 && lat < 50) begin
            @(negedge clk);
            lat++;
        end
    endtask
endmodule // ata_host_model

/* File: verification/ata_set_features_decoder_tb.sv */
// self-checking bench for the set-features decoder
`timescale 1ns/10ps
module ata_set_features_decoder_tb;
    logic clk, rst_n, cmdStrobe, softReset, flushDone, cmdDone, cmdAbort, busy, flushReq;
    logic mode8Bit, assert16Cycle, writeCacheOn, iordyOff, dmaOn, apmOn, apmStandby, pl1On;
    logic extPowerOn, lookAheadOn, cylValid, porDefaultsOnSoft;
    logic [7:0] cmdOpcode, featureIn, sectorCountIn, apmLevel, longBytes, curLimit;
    logic [7:0] cylLowOut, cylHighOut;
    logic [4:0] xferType;
    logic [2:0] xferMode, pioMode, dmaMode;
    logic [3:0] setMaxSel;
    int num_errors = 0, checked = 0, flushCnt = 0, lat;
    ata_set_features_decoder dut_u (
        .clk(clk), .rst_n(rst_n), .cmdStrobe(cmdStrobe), .cmdOpcode(cmdOpcode),
        .featureIn(featureIn), .sectorCountIn(sectorCountIn), .softReset(softReset),
        .flushDone(flushDone), .cmdDone(cmdDone), .cmdAbort(cmdAbort), .busy(busy),
        .flushReq(flushReq), .mode8Bit(mode8Bit), .assert16Cycle(assert16Cycle),
        .writeCacheOn(writeCacheOn), .xferType(xferType), .xferMode(xferMode),
        .iordyOff(iordyOff), .pioMode(pioMode), .dmaOn(dmaOn), .dmaMode(dmaMode),
        .apmOn(apmOn), .apmLevel(apmLevel), .apmStandby(apmStandby), .pl1On(pl1On),
        .extPowerOn(extPowerOn), .lookAheadOn(lookAheadOn), .longBytes(longBytes),
        .curLimit(curLimit), .cylLowOut(cylLowOut), .cylHighOut(cylHighOut),
        .cylValid(cylValid), .porDefaultsOnSoft(porDefaultsOnSoft), .setMaxSel(setMaxSel)
    );
    ata_host_model host_u (
        .clk(clk), .cmdDone(cmdDone), .cmdStrobe(cmdStrobe), .cmdOpcode(cmdOpcode),
        .featureIn(featureIn), .sectorCountIn(sectorCountIn)
    );
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // flash side answers a flush a few cycles late
    always @(negedge clk) begin
        flushCnt <= flushReq ? flushCnt + 1 : 0;
        flushDone <= (flushCnt == 5);
    end
    function automatic logic [7:0] b(input logic x);
        return {7'h00, x};
    endfunction
    task automatic cmp(input string nm, input logic [7:0] e, g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic run(input logic [7:0] op, f, sc, input logic ab);
        host_u.issue(op, f, sc, lat);
        // a host wait that ran out leaves completion low here
        cmp("done", 8'h01, b(cmdDone));
        cmp("abort", b(ab), b(cmdAbort));
    endtask
    task automatic pulseSoft;
        @(negedge clk) softReset = 1'b1;
        @(negedge clk) softReset = 1'b0;
    endtask
    task automatic t_width_cache;
        cmp("wide", 8'h01, b(assert16Cycle));
        run(8'hEF, 8'h01, 8'h00, 1'b0);
        cmp("wide", 8'h00, b(assert16Cycle));
        run(8'hEF, 8'h81, 8'h00, 1'b0);
        cmp("wide", 8'h01, b(assert16Cycle));
        run(8'hEF, 8'h02, 8'h00, 1'b0);
        cmp("cache", 8'h01, b(writeCacheOn));
        run(8'hEF, 8'h82, 8'h00, 1'b0);
        cmp("flushLat", 8'h06, lat[7:0]);
        cmp("cache", 8'h00, b(writeCacheOn));
        $display("test width_cache done");
    endtask
    task automatic t_xfer;
        logic [7:0] sc[8] = '{8'h00, 8'h01, 8'h0C, 8'h0D, 8'h22, 8'h23, 8'h10, 8'h02};
        logic [7:0] ab = 8'hE8;
        foreach (sc[i]) run(8'hEF, 8'h03, sc[i], ab[i]);
        cmp("pio", 8'h04, {5'h00, pioMode});
        cmp("dma", 8'h01, b(dmaOn));
        cmp("dmaMode", 8'h02, {5'h00, dmaMode});
        cmp("type", 8'h04, {3'h0, xferType});
        run(8'hEF, 8'h03, 8'h01, 1'b0);
        cmp("iordy", 8'h01, b(iordyOff));
        cmp("xferMode", 8'h01, {5'h00, xferMode});
        cmp("pio", 8'h00, {5'h00, pioMode});
        $display("test xfer done");
    endtask
    task automatic t_apm;
        cmp("apmLevel", 8'hFE, apmLevel);
        run(8'hEF, 8'h05, 8'h80, 1'b0);
        cmp("standby", 8'h00, b(apmStandby));
        run(8'hEF, 8'h05, 8'h01, 1'b0);
        cmp("standby", 8'h01, b(apmStandby));
        run(8'hEF, 8'h05, 8'hFF, 1'b1);
        run(8'hEF, 8'h05, 8'h00, 1'b1);
        cmp("apmLevel", 8'h01, apmLevel);
        run(8'hEF, 8'h85, 8'h00, 1'b0);
        cmp("apmOn", 8'h00, b(apmOn));
        $display("test apm done");
    endtask
    task automatic t_misc;
        logic [15:0] cv[3] = '{16'h0606, 16'hFF0A, 16'h0104};
        logic [7:0] nop[4] = '{8'h69, 8'h96, 8'h97, 8'hBB};
        cmp("pl1", 8'h01, b(pl1On));
        run(8'hEF, 8'h8A, 8'h00, 1'b0);
        cmp("pl1", 8'h00, b(pl1On));
        cmp("look", 8'h00, b(lookAheadOn));
        cmp("long", 8'h04, longBytes);
        run(8'hEF, 8'hAA, 8'h00, 1'b0);
        cmp("look", 8'h01, b(lookAheadOn));
        cmp("cur", 8'h0A, curLimit);
        foreach (cv[i]) begin
            run(8'hEF, 8'h9A, cv[i][15:8], 1'b0);
            cmp("cur", cv[i][7:0], curLimit);
        end
        cmp("cylLow", 8'h04, cylLowOut);
        cmp("cylHigh", 8'h0A, cylHighOut);
        cmp("cylValid", 8'h01, b(cylValid));
        foreach (nop[i]) run(8'hEF, nop[i], 8'h00, 1'b0);
        run(8'hEF, 8'h09, 8'h00, 1'b0);
        cmp("extPower", 8'h01, b(extPowerOn));
        run(8'hEF, 8'h07, 8'h00, 1'b1);
        run(8'h20, 8'h00, 8'h00, 1'b1);
        $display("test misc done");
    endtask
    task automatic t_setmax;
        for (int i = 1; i < 5; i++) begin
            run(8'hF9, 8'(i), 8'h00, 1'b0);
            cmp("setMax", 8'(1 << (i - 1)), {4'h0, setMaxSel});
        end
        run(8'hF9, 8'h00, 8'h00, 1'b1);
        run(8'hF9, 8'h05, 8'h00, 1'b1);
        run(8'hF9, 8'hFF, 8'h00, 1'b1);
        $display("test setmax done");
    endtask
    task automatic t_soft;
        run(8'hEF, 8'h66, 8'h00, 1'b0);
        pulseSoft();
        cmp("look", 8'h01, b(lookAheadOn));
        run(8'hEF, 8'hCC, 8'h00, 1'b0);
        pulseSoft();
        cmp("look", 8'h00, b(lookAheadOn));
        cmp("por", 8'h01, b(porDefaultsOnSoft));
        $display("test soft done");
    endtask
    task automatic conclude;
        $display("checked %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // watchdog, far beyond the hundred or so cycles the tests need
    initial begin
        #2000000;
        num_errors++;
        conclude();
    end
    initial begin
        rst_n = 1'b0;
        softReset = 1'b0;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        t_width_cache();
        t_xfer();
        t_apm();
        t_misc();
        t_setmax();
        t_soft();
        conclude();
    end
endmodule // ata_set_features_decoder_tb
